//--- ocdc_pkg.sv
/*
 * Shared constants for the output channel divider control block:
 * register indices, field positions, reset values, source codes, states.
 * Assumes an APB bus with 32-bit data and word-aligned registers.
 */
`default_nettype none

package ocdc_pkg;

    // ************************************************
    // bus geometry
    // ************************************************
    localparam int unsigned APB_AW = 12;
    localparam int unsigned APB_DW = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned IDX_W = 10;
    localparam int unsigned IDX_LSB = 2;

    // ************************************************
    // register indices, byte address is four times these
    // ************************************************
    localparam logic [IDX_W-1:0] IDX_A_COUNTS = 10'h190;
    localparam logic [IDX_W-1:0] IDX_A_CTRL = 10'h191;
    localparam logic [IDX_W-1:0] IDX_A_ROUTE = 10'h192;
    localparam logic [IDX_W-1:0] IDX_B_COUNTS = 10'h193;
    localparam logic [IDX_W-1:0] IDX_SRC_SEL = 10'h1e1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h1f0;

    // ************************************************
    // field positions
    // ************************************************
    localparam int unsigned CTRL_BYPASS = 7;
    localparam int unsigned CTRL_NOSYNC = 6;
    localparam int unsigned CTRL_FORCE = 5;
    localparam int unsigned CTRL_START = 4;
    localparam int unsigned CTRL_PHASE_LSB = 0;
    localparam int unsigned ROUTE_DIRECT = 1;
    localparam int unsigned ROUTE_DCC_OFF = 0;
    localparam int unsigned CNT_LOW_LSB = 4;
    localparam int unsigned CNT_HIGH_LSB = 0;
    localparam int unsigned CNT_W = 4;
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned ST_CORE_OUT = 0;
    localparam int unsigned ST_FORCE = 1;
    localparam int unsigned ST_SYNC_HOLD = 2;
    localparam int unsigned ST_DIRECT = 3;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [REG_W-1:0] RST_A_COUNTS = 8'h00;
    localparam logic [REG_W-1:0] RST_A_CTRL = 8'h80;
    localparam logic [REG_W-1:0] RST_A_ROUTE = 8'h00;
    localparam logic [REG_W-1:0] RST_B_COUNTS = 8'h80;
    localparam logic [REG_W-1:0] RST_SRC_SEL = 8'h02;

    // ************************************************
    // clock source selector codes
    // ************************************************
    localparam logic [SEL_W-1:0] SEL_EXT = 2'b00;
    localparam logic [SEL_W-1:0] SEL_NONE = 2'b01;
    localparam logic [SEL_W-1:0] SEL_OSC = 2'b10;

    typedef enum logic [1:0] {
        OCDC_HOLD = 2'b00,
        OCDC_HIGH = 2'b01,
        OCDC_LOW = 2'b10
    } ocdc_state_type;

endpackage

`default_nettype wire

//--- ocdc_sync2.sv
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the level is slow against ref_clk or only its settled value matters.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_sync2 (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);

    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;

    always_comb
    begin
        nxt_meta = ce ? din : meta_ff;
        nxt_sync = ce ? meta_ff : sync_ff;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;

endmodule

`default_nettype wire

//--- ocdc_divider.sv
/*
 * Programmable clock divider core: start level, phase offset, high and
 * low counts. Assumes each ref_clk cycle is one divider input cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_divider (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hold,
    input wire logic start_level,
    input wire logic [ocdc_pkg::CNT_W-1:0] phase_ofs,
    input wire logic [ocdc_pkg::CNT_W-1:0] high_cnt,
    input wire logic [ocdc_pkg::CNT_W-1:0] low_cnt,
    output logic div_out
);

    ocdc_pkg::ocdc_state_type state_ff;
    ocdc_pkg::ocdc_state_type nxt_state;
    logic [ocdc_pkg::CNT_W-1:0] cnt_ff;
    logic [ocdc_pkg::CNT_W-1:0] nxt_cnt;
    logic out_ff;
    logic nxt_out;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff - 4'h1;
        nxt_out = out_ff;
        if (hold)
        begin
            // idle at start level with phase preloaded
            nxt_state = ocdc_pkg::OCDC_HOLD;
            nxt_cnt = phase_ofs;
            nxt_out = start_level;
        end
        else if (cnt_ff == '0)
        begin
            unique case (state_ff)
                ocdc_pkg::OCDC_HOLD:
                begin
                    nxt_state = start_level ? ocdc_pkg::OCDC_HIGH : ocdc_pkg::OCDC_LOW;
                    nxt_cnt = start_level ? high_cnt : low_cnt;
                end
                ocdc_pkg::OCDC_HIGH:
                begin
                    nxt_state = ocdc_pkg::OCDC_LOW;
                    nxt_cnt = low_cnt;
                    nxt_out = 1'b0;
                end
                ocdc_pkg::OCDC_LOW:
                begin
                    nxt_state = ocdc_pkg::OCDC_HIGH;
                    nxt_cnt = high_cnt;
                    nxt_out = 1'b1;
                end
                default:
                begin
                    nxt_state = ocdc_pkg::OCDC_HOLD;
                    nxt_cnt = phase_ofs;
                    nxt_out = start_level;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_ff <= ocdc_pkg::OCDC_HOLD;
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign div_out = out_ff;

endmodule

`default_nettype wire

//--- ocdc_top.sv
/*
 * Output channel divider control: APB register file, sync handling,
 * forcing, bypass and direct routing for output pair A, plus divider B.
 * Assumes ref_clk is the divider input clock; sync_n, internal_oscillator
 * and ext_clk_in arrive from pins and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ocdc_pkg::APB_AW-1:0] paddr,
    input wire logic [ocdc_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ocdc_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_n,
    input wire logic internal_oscillator,
    input wire logic ext_clk_in,
    output logic pair_a_first_output,
    output logic pair_a_second_output,
    output logic pair_b_output,
    output logic duty_fix_enable
);

    // ************************************************
    // register index decode
    // ************************************************
    function automatic logic reg_hit(
        input logic [ocdc_pkg::APB_AW-1:0] addr,
        input logic [ocdc_pkg::IDX_W-1:0] idx
    );
        reg_hit = (addr[ocdc_pkg::APB_AW-1:ocdc_pkg::IDX_LSB] == idx);
    endfunction

    function automatic logic [ocdc_pkg::CNT_W-1:0] nibble(
        input logic [ocdc_pkg::REG_W-1:0] val,
        input int unsigned lsb
    );
        nibble = val[lsb +: ocdc_pkg::CNT_W];
    endfunction

    // ************************************************
    // declarations
    // ************************************************
    logic [ocdc_pkg::REG_W-1:0] a_counts_ff;
    logic [ocdc_pkg::REG_W-1:0] a_ctrl_ff;
    logic [ocdc_pkg::REG_W-1:0] a_route_ff;
    logic [ocdc_pkg::REG_W-1:0] b_counts_ff;
    logic [ocdc_pkg::REG_W-1:0] src_sel_ff;
    logic [ocdc_pkg::REG_W-1:0] nxt_a_counts;
    logic [ocdc_pkg::REG_W-1:0] nxt_a_ctrl;
    logic [ocdc_pkg::REG_W-1:0] nxt_a_route;
    logic [ocdc_pkg::REG_W-1:0] nxt_b_counts;
    logic [ocdc_pkg::REG_W-1:0] nxt_src_sel;
    logic [ocdc_pkg::APB_DW-1:0] prdata_ff;
    logic [ocdc_pkg::APB_DW-1:0] nxt_prdata;
    logic [ocdc_pkg::REG_W-1:0] status_val;
    logic [ocdc_pkg::REG_W-1:0] rd_val;
    logic addr_mapped;
    logic wr_en;
    logic setup_rd;
    logic sync_s;
    logic osc_s;
    logic ext_s;
    logic bypass;
    logic nosync;
    logic force_bit;
    logic start_level;
    logic direct;
    logic [ocdc_pkg::SEL_W-1:0] src_sel;
    logic sync_hold;
    logic force_active;
    logic core_hold;
    logic core_a_out;
    logic core_b_out;
    logic div_src;
    logic path_a;
    logic direct_active;
    logic pair_a_ff;
    logic pair_b_ff;
    logic dcc_en_ff;
    logic nxt_pair_a;
    logic nxt_pair_b;
    logic nxt_dcc_en;

    // ************************************************
    // pin synchronisers
    // ************************************************
    ocdc_sync2 u_sync_pin (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .din(~sync_n),
        .dout(sync_s)
    );

    ocdc_sync2 u_sync_osc (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .din(internal_oscillator),
        .dout(osc_s)
    );

    ocdc_sync2 u_sync_ext (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .din(ext_clk_in),
        .dout(ext_s)
    );

    // ************************************************
    // apb slave
    // ************************************************
    assign addr_mapped = reg_hit(paddr, ocdc_pkg::IDX_A_COUNTS)
                       | reg_hit(paddr, ocdc_pkg::IDX_A_CTRL)
                       | reg_hit(paddr, ocdc_pkg::IDX_A_ROUTE)
                       | reg_hit(paddr, ocdc_pkg::IDX_B_COUNTS)
                       | reg_hit(paddr, ocdc_pkg::IDX_SRC_SEL)
                       | reg_hit(paddr, ocdc_pkg::IDX_STATUS);

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped;
    assign wr_en = psel & penable & pwrite & addr_mapped & pstrb[0];
    assign setup_rd = psel & ~penable & ~pwrite;

    always_comb
    begin
        rd_val = '0;
        if (reg_hit(paddr, ocdc_pkg::IDX_A_COUNTS))
            rd_val = a_counts_ff;
        else if (reg_hit(paddr, ocdc_pkg::IDX_A_CTRL))
            rd_val = a_ctrl_ff;
        else if (reg_hit(paddr, ocdc_pkg::IDX_A_ROUTE))
            rd_val = a_route_ff;
        else if (reg_hit(paddr, ocdc_pkg::IDX_B_COUNTS))
            rd_val = b_counts_ff;
        else if (reg_hit(paddr, ocdc_pkg::IDX_SRC_SEL))
            rd_val = src_sel_ff;
        else if (reg_hit(paddr, ocdc_pkg::IDX_STATUS))
            rd_val = status_val;
    end

    always_comb
    begin
        nxt_a_counts = a_counts_ff;
        nxt_a_ctrl = a_ctrl_ff;
        nxt_a_route = a_route_ff;
        nxt_b_counts = b_counts_ff;
        nxt_src_sel = src_sel_ff;
        nxt_prdata = prdata_ff;
        if (setup_rd)
            nxt_prdata = {{(ocdc_pkg::APB_DW-ocdc_pkg::REG_W){1'b0}}, rd_val};
        if (wr_en)
        begin
            if (reg_hit(paddr, ocdc_pkg::IDX_A_COUNTS))
                nxt_a_counts = pwdata[ocdc_pkg::REG_W-1:0];
            if (reg_hit(paddr, ocdc_pkg::IDX_A_CTRL))
                nxt_a_ctrl = pwdata[ocdc_pkg::REG_W-1:0];
            if (reg_hit(paddr, ocdc_pkg::IDX_A_ROUTE))
                nxt_a_route = pwdata[ocdc_pkg::REG_W-1:0] & 8'h03;
            if (reg_hit(paddr, ocdc_pkg::IDX_B_COUNTS))
                nxt_b_counts = pwdata[ocdc_pkg::REG_W-1:0];
            if (reg_hit(paddr, ocdc_pkg::IDX_SRC_SEL))
                nxt_src_sel = pwdata[ocdc_pkg::REG_W-1:0] & 8'h03;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            a_counts_ff <= ocdc_pkg::RST_A_COUNTS;
            a_ctrl_ff <= ocdc_pkg::RST_A_CTRL;
            a_route_ff <= ocdc_pkg::RST_A_ROUTE;
            b_counts_ff <= ocdc_pkg::RST_B_COUNTS;
            src_sel_ff <= ocdc_pkg::RST_SRC_SEL;
            prdata_ff <= '0;
        end
        else if (ce)
        begin
            a_counts_ff <= nxt_a_counts;
            a_ctrl_ff <= nxt_a_ctrl;
            a_route_ff <= nxt_a_route;
            b_counts_ff <= nxt_b_counts;
            src_sel_ff <= nxt_src_sel;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

    // ************************************************
    // control decode
    // ************************************************
    assign bypass = a_ctrl_ff[ocdc_pkg::CTRL_BYPASS];
    assign nosync = a_ctrl_ff[ocdc_pkg::CTRL_NOSYNC];
    assign force_bit = a_ctrl_ff[ocdc_pkg::CTRL_FORCE];
    assign start_level = a_ctrl_ff[ocdc_pkg::CTRL_START];
    assign direct = a_route_ff[ocdc_pkg::ROUTE_DIRECT];
    assign src_sel = src_sel_ff[ocdc_pkg::SEL_LSB +: ocdc_pkg::SEL_W];

    assign sync_hold = ~nosync & sync_s;
    assign force_active = nosync & force_bit & ~bypass;
    assign core_hold = sync_hold | bypass;
    assign direct_active = direct & ((src_sel == ocdc_pkg::SEL_OSC)
                         | (src_sel == ocdc_pkg::SEL_EXT));

    assign status_val = {4'h0, direct_active, sync_hold, force_active, core_a_out};

    // ************************************************
    // dividers
    // ************************************************
    ocdc_divider u_div_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .hold(core_hold),
        .start_level(start_level),
        .phase_ofs(nibble(a_ctrl_ff, ocdc_pkg::CTRL_PHASE_LSB)),
        .high_cnt(nibble(a_counts_ff, ocdc_pkg::CNT_HIGH_LSB)),
        .low_cnt(nibble(a_counts_ff, ocdc_pkg::CNT_LOW_LSB)),
        .div_out(core_a_out)
    );

    ocdc_divider u_div_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .hold(sync_s),
        .start_level(1'b0),
        .phase_ofs(4'h0),
        .high_cnt(nibble(b_counts_ff, ocdc_pkg::CNT_HIGH_LSB)),
        .low_cnt(nibble(b_counts_ff, ocdc_pkg::CNT_LOW_LSB)),
        .div_out(core_b_out)
    );

    // ************************************************
    // output routing
    // ************************************************
    // bypass path follows the selected source; external unless oscillator chosen
    assign div_src = (src_sel == ocdc_pkg::SEL_OSC) ? osc_s : ext_s;

    always_comb
    begin
        if (bypass)
            path_a = div_src;
        else if (force_active)
            path_a = force_bit;
        else
            path_a = core_a_out;
    end

    always_comb
    begin
        nxt_pair_a = path_a;
        if (direct && src_sel == ocdc_pkg::SEL_OSC)
            nxt_pair_a = osc_s;
        else if (direct && src_sel == ocdc_pkg::SEL_EXT)
            nxt_pair_a = ext_s;
        nxt_pair_b = core_b_out;
        nxt_dcc_en = ~a_route_ff[ocdc_pkg::ROUTE_DCC_OFF];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pair_a_ff <= 1'b0;
            pair_b_ff <= 1'b0;
            dcc_en_ff <= 1'b1;
        end
        else if (ce)
        begin
            pair_a_ff <= nxt_pair_a;
            pair_b_ff <= nxt_pair_b;
            dcc_en_ff <= nxt_dcc_en;
        end
    end

    assign pair_a_first_output = pair_a_ff;
    assign pair_a_second_output = pair_a_ff;
    assign pair_b_output = pair_b_ff;
    assign duty_fix_enable = dcc_en_ff;

endmodule

`default_nettype wire

//--- ocdc_rx_model.sv
/*
 * Clock receiver on one output line: measures the last high and low runs.
 * Assumes the line changes only at ref_clk edges.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_rx_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_in,
    output logic [7:0] hi_len,
    output logic [7:0] lo_len
);
    logic prev_ff;
    logic [7:0] run_ff;
    logic [7:0] nxt_run;
    logic changed;

    // ********
    // run length capture
    // ********
    always_comb
    begin
        changed = clk_in != prev_ff;
        nxt_run = changed ? 8'h01 : run_ff + 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        prev_ff <= rst ? 1'b0 : clk_in;
        run_ff <= rst ? 8'h00 : nxt_run;
        hi_len <= rst ? 8'h00 : ((changed && prev_ff) ? run_ff : hi_len);
        lo_len <= rst ? 8'h00 : ((changed && !prev_ff) ? run_ff : lo_len);
    end
endmodule

`default_nettype wire

//--- ocdc_top_sva.sv
/*
 * Port checker for ocdc_top, shadows the control registers from APB writes.
 * Assumes ce high while route, force or hold checks are armed, and a
 * pin to output latency of three cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_top_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ocdc_pkg::APB_AW-1:0] paddr,
    input wire logic [ocdc_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [ocdc_pkg::APB_DW-1:0] prdata,
    input wire logic pslverr,
    input wire logic sync_n,
    input wire logic internal_oscillator,
    input wire logic ext_clk_in,
    input wire logic pair_a_first_output,
    input wire logic pair_a_second_output,
    input wire logic duty_fix_enable
);
    logic [ocdc_pkg::IDX_W-1:0] idx;
    logic wr;
    logic mapped;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [1:0] route_ff;
    logic [1:0] nxt_route;
    logic [1:0] sel_ff;
    logic [1:0] nxt_sel;
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    logic [2:0] slow_ff;
    logic [2:0] nxt_slow;

    // ********
    // register shadows and settle counters
    // ********
    always_comb
    begin
        idx = paddr[11:2];
        wr = psel && penable && pwrite && pstrb[0];
        mapped = idx inside {ocdc_pkg::IDX_A_COUNTS, ocdc_pkg::IDX_A_CTRL,
            ocdc_pkg::IDX_A_ROUTE, ocdc_pkg::IDX_B_COUNTS, ocdc_pkg::IDX_SRC_SEL,
            ocdc_pkg::IDX_STATUS};
        nxt_ctrl = (wr && idx == ocdc_pkg::IDX_A_CTRL) ? pwdata[7:0] : ctrl_ff;
        nxt_route = (wr && idx == ocdc_pkg::IDX_A_ROUTE) ? pwdata[1:0] : route_ff;
        nxt_sel = (wr && idx == ocdc_pkg::IDX_SRC_SEL) ? pwdata[1:0] : sel_ff;
        nxt_quiet = (psel && pwrite) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
        nxt_slow = sync_n ? 3'h0 : slow_ff + {2'h0, slow_ff != 3'h7};
    end

    always_ff @(posedge ref_clk)
    begin
        ctrl_ff <= rst ? 8'h80 : nxt_ctrl;
        route_ff <= rst ? 2'h0 : nxt_route;
        sel_ff <= rst ? 2'h2 : nxt_sel;
        quiet_ff <= rst ? 3'h0 : nxt_quiet;
        slow_ff <= rst ? 3'h0 : nxt_slow;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_err_map: assert property (pslverr == (psel && penable && !mapped))
        else $error("slave error does not match address map");
    chk_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_pair_same: assert property (pair_a_first_output == pair_a_second_output)
        else $error("pair outputs differ");
    chk_duty_map: assert property ($stable(route_ff) |-> duty_fix_enable == !route_ff[0])
        else $error("duty enable wrong");
    chk_osc_route: assert property (quiet_ff > 3'h4 && (ctrl_ff[7] || route_ff[1])
        && sel_ff == 2'h2 |-> pair_a_first_output == $past(internal_oscillator, 3))
        else $error("oscillator not routed");
    chk_ext_route: assert property (quiet_ff > 3'h4 && route_ff[1] && sel_ff == 2'h0
        |-> pair_a_first_output == $past(ext_clk_in, 3))
        else $error("external clock not routed");
    chk_force_high: assert property (quiet_ff > 3'h4 && ctrl_ff[7:5] == 3'h3
        && !route_ff[1] |-> pair_a_first_output)
        else $error("forced level not held");
    chk_sync_hold: assert property (slow_ff > 3'h5 && quiet_ff > 3'h5
        && ctrl_ff[7:6] == 2'h0 && !route_ff[1] |-> pair_a_first_output == ctrl_ff[4])
        else $error("sync hold level wrong");
endmodule

bind ocdc_top ocdc_top_sva u_sva (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pslverr(pslverr), .sync_n(sync_n),
    .internal_oscillator(internal_oscillator), .ext_clk_in(ext_clk_in),
    .pair_a_first_output(pair_a_first_output), .pair_a_second_output(pair_a_second_output),
    .duty_fix_enable(duty_fix_enable));

`default_nettype wire

//--- ocdc_top_tb.sv
/*
 * Self-checking bench for ocdc_top: registers, routing, dividers, sync, force.
 * Assumes ocdc_pkg, the design, the receiver model and the checker are compiled.
 */
`timescale 1ns/1ns
`default_nettype none

module ocdc_top_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ocdc_pkg::APB_AW-1:0] paddr = 12'h000;
    logic [ocdc_pkg::APB_DW-1:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic sync_n = 1'b1;
    logic ce = 1'b1;
    logic osc = 1'b0;
    logic ext = 1'b0;
    logic [1:0] t3 = 2'h0;
    logic [2:0] t5 = 3'h0;
    logic [ocdc_pkg::APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic pa1;
    logic pb;
    logic duty;
    logic [7:0] a_hi;
    logic [7:0] a_lo;
    logic [7:0] b_hi;
    logic [7:0] b_lo;
    logic [31:0] rd_v;
    logic err_v;
    logic [7:0] c;
    logic [9:0] idx_t [5] = '{10'h190, 10'h191, 10'h192, 10'h193, 10'h1e1};
    logic [7:0] rst_t [5] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h02};
    logic [7:0] cnt_t [4] = '{8'h00, 8'hf0, 8'h0f, 8'h5a};
    logic [7:0] ph_t [3] = '{8'h10, 8'h00, 8'h05};
    int lat [3];
    int n;
    int err_count = 0;
    int total_checks = 0;

    initial
    begin
        forever #5 ref_clk = !ref_clk;
    end

    // sources with runs of three and five cycles
    always @(posedge ref_clk)
    begin
        t3 <= (t3 == 2'h2) ? 2'h0 : t3 + 2'h1;
        t5 <= (t5 == 3'h4) ? 3'h0 : t5 + 3'h1;
        osc <= (t3 == 2'h2) ? !osc : osc;
        ext <= (t5 == 3'h4) ? !ext : ext;
    end

    ocdc_top u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_n(sync_n), .internal_oscillator(osc),
        .ext_clk_in(ext), .pair_a_first_output(pa1), .pair_a_second_output(),
        .pair_b_output(pb), .duty_fix_enable(duty));
    ocdc_rx_model u_rx_a (.ref_clk(ref_clk), .rst(rst), .clk_in(pa1), .hi_len(a_hi),
        .lo_len(a_lo));
    ocdc_rx_model u_rx_b (.ref_clk(ref_clk), .rst(rst), .clk_in(pb), .hi_len(b_hi),
        .lo_len(b_lo));

    // ********
    // tasks
    // ********
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
        input logic [3:0] s);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        chk("ready answer", 32'h1, {31'h0, pready});
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'h1);
    endtask

    task automatic meas_a(input logic [7:0] h, input logic [7:0] l);
        repeat (60) @(posedge ref_clk);
        chk("pair a high run", {24'h0, h}, {24'h0, a_hi});
        chk("pair a low run", {24'h0, l}, {24'h0, a_lo});
    endtask

    task automatic toggles();
        logic last;
        n = 0;
        last = pa1;
        repeat (40)
        begin
            @(posedge ref_clk);
            n += int'(pa1 !== last);
            last = pa1;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end

    // ********
    // test sequence
    // ********
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, idx_t[i], 8'h00, 4'h0);
            chk("reset value", {24'h0, rst_t[i]}, rd_v);
        end
        chk("duty enable", 32'h1, {31'h0, duty});
        apb(1'b0, 10'h000, 8'h00, 4'h0);
        chk("unmapped error", 32'h1, {31'h0, err_v});
        chk("unmapped data", 32'h0, rd_v);
        apb(1'b1, ocdc_pkg::IDX_A_ROUTE, 8'h03, 4'h0);
        apb(1'b0, ocdc_pkg::IDX_A_ROUTE, 8'h00, 4'h0);
        chk("masked write", 32'h0, rd_v);
        meas_a(8'h03, 8'h03);
        wr(ocdc_pkg::IDX_A_CTRL, 8'h00);
        wr(ocdc_pkg::IDX_A_COUNTS, 8'h21);
        wr(ocdc_pkg::IDX_A_ROUTE, 8'h03);
        wr(ocdc_pkg::IDX_SRC_SEL, 8'h00);
        meas_a(8'h05, 8'h05);
        chk("duty enable", 32'h0, {31'h0, duty});
        wr(ocdc_pkg::IDX_SRC_SEL, 8'h02);
        meas_a(8'h03, 8'h03);
        wr(ocdc_pkg::IDX_SRC_SEL, 8'h01);
        meas_a(8'h02, 8'h03);
        wr(ocdc_pkg::IDX_A_ROUTE, 8'h00);
        wr(ocdc_pkg::IDX_SRC_SEL, 8'h00);
        meas_a(8'h02, 8'h03);
        ce <= 1'b0;
        @(posedge ref_clk);
        toggles();
        ce <= 1'b1;
        chk("frozen by enable", 32'h0, n);
        for (int i = 0; i < 4; i++)
        begin
            c = cnt_t[i];
            wr(ocdc_pkg::IDX_A_COUNTS, c);
            wr(ocdc_pkg::IDX_B_COUNTS, c);
            meas_a({4'h0, c[3:0]} + 8'h01, {4'h0, c[7:4]} + 8'h01);
            chk("pair b low run", {28'h0, c[7:4]} + 32'h1, {24'h0, b_lo});
        end
        wr(ocdc_pkg::IDX_A_COUNTS, 8'h11);
        for (int i = 0; i < 3; i++)
        begin
            wr(ocdc_pkg::IDX_A_CTRL, ph_t[i]);
            sync_n <= 1'b0;
            repeat (12) @(posedge ref_clk);
            chk("sync hold level", {31'h0, ph_t[i][4]}, {31'h0, pa1});
            sync_n <= 1'b1;
            lat[i] = 0;
            while (pa1 === ph_t[i][4] && lat[i] < 100)
            begin
                @(posedge ref_clk);
                lat[i]++;
            end
        end
        chk("phase delay", 32'h5, lat[2] - lat[1]);
        wr(ocdc_pkg::IDX_A_CTRL, 8'h40);
        sync_n <= 1'b0;
        toggles();
        chk("nosync running", 32'h1, {31'h0, n > 0});
        wr(ocdc_pkg::IDX_A_CTRL, 8'h60);
        repeat (8) @(posedge ref_clk);
        chk("forced high", 32'h1, {31'h0, pa1});
        apb(1'b0, ocdc_pkg::IDX_STATUS, 8'h00, 4'h0);
        chk("status force active", 32'h2, rd_v & 32'he);
        sync_n <= 1'b1;
        wr(ocdc_pkg::IDX_A_CTRL, 8'h20);
        toggles();
        chk("force without nosync", 32'h1, {31'h0, n > 0});
        wr(ocdc_pkg::IDX_SRC_SEL, 8'h02);
        wr(ocdc_pkg::IDX_A_CTRL, 8'he0);
        meas_a(8'h03, 8'h03);
        stop_test();
    end
endmodule

`default_nettype wire
